// file: tsps_params.svh
`ifndef TSPS_PARAMS_SVH
`define TSPS_PARAMS_SVH

// ----------------------------------------
// Clock and time units
// ----------------------------------------
`define TSPS_CLK_MHZ     200
`define TSPS_NS_PER_US   1000

// ----------------------------------------
// Bus delays in ns
// ----------------------------------------
`define TSPS_T_SETTLE_NS 400
`define TSPS_T_DESKEW_NS 45
`define TSPS_T_CSKEW_NS  10
`define TSPS_T_DREL_NS   400

// ----------------------------------------
// Phase line codes {msg, cd, io}
// ----------------------------------------
`define TSPS_PH_DATA_OUT 3'h0
`define TSPS_PH_DATA_IN  3'h1
`define TSPS_PH_COMMAND  3'h2
`define TSPS_PH_STATUS   3'h3
`define TSPS_PH_MSG_OUT  3'h6
`define TSPS_PH_MSG_IN   3'h7

// ----------------------------------------
// Widths and positions
// ----------------------------------------
`define TSPS_CNT_W       16
`define TSPS_DLY_W       10
`define TSPS_FIFO_DEPTH  16
`define TSPS_PAR_BIT     8
`define TSPS_SYNC_W      12
`define TSPS_SB_RST      11
`define TSPS_SB_ATN      10
`define TSPS_SB_ACK      9

`endif

// file: tsps_pkg.sv
`include "tsps_params.svh"

package tsps_pkg;

    // ----------------------------------------
    // Bus and command types
    // ----------------------------------------
    typedef struct packed {
        logic msg;
        logic cd;
        logic io;
    } tsps_lines_type;

    typedef enum logic [1:0] {
        TSPS_CMD_CONNECT,
        TSPS_CMD_PHASE,
        TSPS_CMD_FREE
    } tsps_op_type;

    typedef struct packed {
        tsps_op_type               op;
        tsps_lines_type            phase;
        logic [`TSPS_CNT_W-1:0]    count;
    } tsps_cmd_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       par_err;
    } tsps_rx_type;

    typedef enum logic [2:0] {
        TSPS_ST_FREE,
        TSPS_ST_CONN,
        TSPS_ST_SETTLE,
        TSPS_ST_LOAD,
        TSPS_ST_SETUP,
        TSPS_ST_REQ,
        TSPS_ST_ACKN,
        TSPS_ST_RESET
    } tsps_state_type;

endpackage

// file: tsps_fifo.sv
`timescale 1ns/10ps
`include "tsps_params.svh"

module tsps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `TSPS_FIFO_DEPTH
)(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [CW-1:0]    cnt_ff;
    logic             in_ready_ff;
    logic             out_valid_ff;

    wire              push   = in_valid & in_ready_ff;
    wire              pop    = out_valid_ff & out_ready;
    wire [AW-1:0]     wr_nxt = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
    wire [AW-1:0]     rd_nxt = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
    wire [CW-1:0]     nxt_cnt = cnt_ff + CW'(push) - CW'(pop);

    assign in_ready  = in_ready_ff;
    assign out_valid = out_valid_ff;
    assign out_data  = mem_ff[rd_ff];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ff        <= '0;
            rd_ff        <= '0;
            cnt_ff       <= '0;
            in_ready_ff  <= 1'b1;
            out_valid_ff <= 1'b0;
        end else begin
            wr_ff        <= push ? wr_nxt : wr_ff;
            rd_ff        <= pop ? rd_nxt : rd_ff;
            cnt_ff       <= nxt_cnt;
            in_ready_ff  <= nxt_cnt != CW'(DEPTH);
            out_valid_ff <= nxt_cnt != '0;
        end
    end

endmodule

// file: tsps_phase_seq.sv
// Operation
// - Command phase: C/D on, I/O, MSG off
// - Data in: I/O only; data out: none
// - Status phase: C/D and I/O on
// - Message in: all three lines on
// - Message out: C/D and MSG on
// - Message phases carry whole messages only
// - Message out entered later, by choice
// - Message out bytes continue while ATN held
// - After clean message out, change phase
// - Between phases only phase, data lines change
// - Turn toward initiator: release plus settle wait
// - Turn toward target: free data promptly
// - Bus reset releases all, goes free
// - Never drive RST, always obey it
// - Free, then connection, then transfer phases
// - Without arbitration, selection precedes transfers
// - Transfer phases follow in any order
// - Skip save pointer when nothing to save
// - Phase lines stable settle through last ACK
// - BSY held, one byte per handshake
`timescale 1ns/10ps
`include "tsps_params.svh"

module tsps_phase_seq
    import tsps_pkg::*;
#(
    parameter int CNT_W       = `TSPS_CNT_W,
    parameter int DLY_W       = `TSPS_DLY_W,
    parameter int FIFO_DEPTH  = `TSPS_FIFO_DEPTH,
    parameter int T_SETTLE_NS = `TSPS_T_SETTLE_NS,
    parameter int T_DESKEW_NS = `TSPS_T_DESKEW_NS,
    parameter int T_CSKEW_NS  = `TSPS_T_CSKEW_NS,
    parameter int T_DREL_NS   = `TSPS_T_DREL_NS
)(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         cmd_valid,
    input  wire tsps_cmd_type cmd,
    output logic              cmd_ready,
    output logic              done,
    output logic              done_err,
    input  wire logic         tx_valid,
    input  wire logic [7:0]   tx_data,
    output logic              tx_ready,
    output tsps_rx_type       rx,
    input  wire logic         xfer_all,
    output logic              atn_seen,
    output logic              sdp_due,
    input  wire logic         scsi_rst_i,
    input  wire logic         atn_i,
    input  wire logic         ack_i,
    input  wire logic [8:0]   db_i,
    output logic [8:0]        db_o,
    output logic              db_oe,
    output logic              bsy_oe,
    output logic              req_oe,
    output tsps_lines_type    lines_oe
);

    // ----------------------------------------
    // Delay counts
    // ----------------------------------------
    function automatic int cyc_ceil(input int t_ns);
        int c;
        c = (t_ns * `TSPS_CLK_MHZ + `TSPS_NS_PER_US - 1) / `TSPS_NS_PER_US;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CYC_SETTLE = cyc_ceil(T_SETTLE_NS);
    localparam int CYC_TURN   = cyc_ceil(T_DREL_NS) + CYC_SETTLE;
    localparam int CYC_SETUP  = cyc_ceil(T_DESKEW_NS + T_CSKEW_NS);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [`TSPS_SYNC_W-1:0] s1_ff;
    logic [`TSPS_SYNC_W-1:0] s2_ff;
    logic [`TSPS_SYNC_W-1:0] s3_ff;
    logic [`TSPS_SYNC_W-1:0] flt_ff;

    wire [`TSPS_SYNC_W-1:0]  pin_vec = {scsi_rst_i, atn_i, ack_i, db_i};
    wire [`TSPS_SYNC_W-1:0]  agree   = ~(s2_ff ^ s3_ff);
    wire [`TSPS_SYNC_W-1:0]  nxt_flt = (s3_ff & agree) | (flt_ff & ~agree);

    wire                     bus_rst = flt_ff[`TSPS_SB_RST];
    wire                     atn_f   = flt_ff[`TSPS_SB_ATN];
    wire                     ack_f   = flt_ff[`TSPS_SB_ACK];
    wire [8:0]               db_f    = flt_ff[8:0];

    always_ff @(posedge clock) begin
        if (rst) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            flt_ff <= '0;
        end else begin
            s1_ff  <= pin_vec;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            flt_ff <= nxt_flt;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    tsps_state_type     state_ff;
    tsps_state_type     nxt_state;
    tsps_lines_type     lines_ff;
    tsps_lines_type     nxt_lines;
    tsps_rx_type        rx_ff;
    tsps_rx_type        nxt_rx;
    logic               bsy_ff;
    logic               nxt_bsy;
    logic               req_ff;
    logic               nxt_req;
    logic [8:0]         db_o_ff;
    logic [8:0]         nxt_db_o;
    logic               db_oe_ff;
    logic               nxt_db_oe;
    logic [DLY_W-1:0]   dly_ff;
    logic [DLY_W-1:0]   nxt_dly;
    logic [CNT_W-1:0]   left_ff;
    logic [CNT_W-1:0]   nxt_left;
    logic               ready_ff;
    logic               done_ff;
    logic               nxt_done;
    logic               err_ff;
    logic               nxt_err;
    logic               moved_ff;
    logic               nxt_moved;
    logic               wr_dir_ff;
    logic               nxt_wr_dir;
    logic               mo_ok_ff;
    logic               nxt_mo_ok;
    logic               par_bad_ff;
    logic               nxt_par_bad;
    logic               atn_ff;
    logic               sdp_ff;

    // ----------------------------------------
    // Transmit buffer
    // ----------------------------------------
    logic               f_valid;
    logic [7:0]         f_data;
    wire                f_pop = (state_ff == TSPS_ST_LOAD) & ~bus_rst;

    tsps_fifo #(
        .WIDTH     (8),
        .DEPTH     (FIFO_DEPTH)
    ) u_tx_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (tx_valid),
        .in_data   (tx_data),
        .in_ready  (tx_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_pop)
    );

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire take      = cmd_valid & ready_ff;
    wire op_conn   = cmd.op == TSPS_CMD_CONNECT;
    wire op_phase  = cmd.op == TSPS_CMD_PHASE;
    wire op_free   = cmd.op == TSPS_CMD_FREE;
    wire ph_resv   = cmd.phase.msg & ~cmd.phase.cd;
    wire ph_mo     = cmd.phase == `TSPS_PH_MSG_OUT;
    wire ph_mi     = cmd.phase == `TSPS_PH_MSG_IN;
    wire mo_bad    = ph_mo & (mo_ok_ff | ~atn_f);
    wire cnt_bad   = ~ph_mo & (cmd.count == '0);
    wire ph_bad    = ph_resv | mo_bad | cnt_bad;
    wire turn_in   = cmd.phase.io & ~db_oe_ff;
    wire dly_done  = dly_ff == '0;
    wire cur_mo    = lines_ff == `TSPS_PH_MSG_OUT;
    wire cur_mi    = lines_ff == `TSPS_PH_MSG_IN;
    wire cur_data  = ~lines_ff.msg & ~lines_ff.cd;
    wire more      = cur_mo ? atn_f : (left_ff != '0);
    wire par_ok    = ^db_f;
    wire in_phase  = (state_ff != TSPS_ST_FREE) & (state_ff != TSPS_ST_CONN)
                   & (state_ff != TSPS_ST_RESET);
    wire [DLY_W-1:0] dly_turn   = DLY_W'(CYC_TURN - 1);
    wire [DLY_W-1:0] dly_settle = DLY_W'(CYC_SETTLE - 1);
    wire [DLY_W-1:0] dly_setup  = DLY_W'(CYC_SETUP - 1);
    wire [CNT_W-1:0] left_dec   = (left_ff != '0) ? left_ff - 1'b1 : left_ff;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        nxt_state   = state_ff;
        nxt_lines   = lines_ff;
        nxt_bsy     = bsy_ff;
        nxt_req     = req_ff;
        nxt_db_o    = db_o_ff;
        nxt_db_oe   = db_oe_ff;
        nxt_dly     = dly_done ? dly_ff : dly_ff - 1'b1;
        nxt_left    = left_ff;
        nxt_done    = 1'b0;
        nxt_err     = 1'b0;
        nxt_rx      = '0;
        nxt_moved   = moved_ff;
        nxt_wr_dir  = wr_dir_ff;
        nxt_mo_ok   = mo_ok_ff;
        nxt_par_bad = par_bad_ff;
        if (bus_rst) begin
            // Drop every driven line at once, abandon the phase
            nxt_state = TSPS_ST_RESET;
            nxt_lines = '0;
            nxt_bsy   = 1'b0;
            nxt_req   = 1'b0;
            nxt_db_oe = 1'b0;
            nxt_moved = 1'b0;
            nxt_mo_ok = 1'b0;
            nxt_done  = in_phase;
            nxt_err   = in_phase;
        end else begin
            case (state_ff)
                TSPS_ST_RESET: begin
                    nxt_state = TSPS_ST_FREE;
                end
                TSPS_ST_FREE: begin
                    if (take) begin
                        nxt_done = 1'b1;
                        nxt_err  = ~op_conn;
                        if (op_conn) begin
                            nxt_bsy   = 1'b1;
                            nxt_moved = 1'b0;
                            nxt_mo_ok = 1'b0;
                            nxt_state = TSPS_ST_CONN;
                        end
                    end
                end
                TSPS_ST_CONN: begin
                    if (take) begin
                        if (op_free) begin
                            nxt_done  = 1'b1;
                            nxt_lines = '0;
                            nxt_bsy   = 1'b0;
                            nxt_db_oe = 1'b0;
                            nxt_state = TSPS_ST_FREE;
                        end else if (op_conn | (op_phase & ph_bad)) begin
                            nxt_done = 1'b1;
                            nxt_err  = 1'b1;
                        end else begin
                            // Only phase and data lines move here
                            nxt_lines   = cmd.phase;
                            nxt_left    = cmd.count;
                            nxt_par_bad = 1'b0;
                            nxt_mo_ok   = 1'b0;
                            nxt_db_oe   = cmd.phase.io & db_oe_ff;
                            nxt_dly     = turn_in ? dly_turn : dly_settle;
                            nxt_state   = TSPS_ST_SETTLE;
                            if (ph_mi) begin
                                nxt_moved = 1'b0;
                            end
                        end
                    end
                end
                TSPS_ST_SETTLE: begin
                    if (dly_done) begin
                        nxt_req   = ~lines_ff.io;
                        nxt_state = lines_ff.io ? TSPS_ST_LOAD : TSPS_ST_REQ;
                    end
                end
                TSPS_ST_LOAD: begin
                    if (f_valid) begin
                        nxt_db_o  = {~^f_data, f_data};
                        nxt_db_oe = 1'b1;
                        nxt_dly   = dly_setup;
                        nxt_state = TSPS_ST_SETUP;
                    end
                end
                TSPS_ST_SETUP: begin
                    if (dly_done) begin
                        nxt_req   = 1'b1;
                        nxt_state = TSPS_ST_REQ;
                    end
                end
                TSPS_ST_REQ: begin
                    if (ack_f) begin
                        // Exactly one byte per handshake
                        nxt_req  = 1'b0;
                        nxt_left = left_dec;
                        nxt_state = TSPS_ST_ACKN;
                        if (~lines_ff.io) begin
                            nxt_rx.valid   = 1'b1;
                            nxt_rx.data    = db_f[7:0];
                            nxt_rx.par_err = ~par_ok;
                        end
                        if (cur_data) begin
                            nxt_moved  = 1'b1;
                            nxt_wr_dir = ~lines_ff.io;
                        end
                        if (cur_mo & ~par_ok) begin
                            nxt_par_bad = 1'b1;
                        end
                    end
                end
                TSPS_ST_ACKN: begin
                    if (~ack_f) begin
                        if (more) begin
                            // Message stays whole inside one phase
                            nxt_req   = ~lines_ff.io;
                            nxt_state = lines_ff.io ? TSPS_ST_LOAD : TSPS_ST_REQ;
                        end else begin
                            nxt_done  = 1'b1;
                            nxt_err   = cur_mo & par_bad_ff;
                            nxt_mo_ok = cur_mo & ~par_bad_ff;
                            nxt_moved = cur_mi ? moved_ff : moved_ff;
                            nxt_state = TSPS_ST_CONN;
                        end
                    end
                end
                default: begin
                    nxt_state = TSPS_ST_FREE;
                end
            endcase
        end
    end

    wire nxt_ready = ~bus_rst
                   & ((nxt_state == TSPS_ST_FREE) | (nxt_state == TSPS_ST_CONN));

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff   <= TSPS_ST_FREE;
            lines_ff   <= '0;
            bsy_ff     <= 1'b0;
            req_ff     <= 1'b0;
            db_o_ff    <= '0;
            db_oe_ff   <= 1'b0;
            dly_ff     <= '0;
            left_ff    <= '0;
            ready_ff   <= 1'b0;
            done_ff    <= 1'b0;
            err_ff     <= 1'b0;
            rx_ff      <= '0;
            moved_ff   <= 1'b0;
            wr_dir_ff  <= 1'b0;
            mo_ok_ff   <= 1'b0;
            par_bad_ff <= 1'b0;
            atn_ff     <= 1'b0;
            sdp_ff     <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            lines_ff   <= nxt_lines;
            bsy_ff     <= nxt_bsy;
            req_ff     <= nxt_req;
            db_o_ff    <= nxt_db_o;
            db_oe_ff   <= nxt_db_oe;
            dly_ff     <= nxt_dly;
            left_ff    <= nxt_left;
            ready_ff   <= nxt_ready;
            done_ff    <= nxt_done;
            err_ff     <= nxt_err;
            rx_ff      <= nxt_rx;
            moved_ff   <= nxt_moved;
            wr_dir_ff  <= nxt_wr_dir;
            mo_ok_ff   <= nxt_mo_ok;
            par_bad_ff <= nxt_par_bad;
            atn_ff     <= atn_f;
            sdp_ff     <= moved_ff & ~(wr_dir_ff & xfer_all);
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign cmd_ready = ready_ff;
    assign done      = done_ff;
    assign done_err  = err_ff;
    assign rx        = rx_ff;
    assign atn_seen  = atn_ff;
    assign sdp_due   = sdp_ff;
    assign db_o      = db_o_ff;
    assign db_oe     = db_oe_ff;
    assign bsy_oe    = bsy_ff;
    assign req_oe    = req_ff;
    assign lines_oe  = lines_ff;

endmodule

// file: tsps_phase_seq_properties.sv
`timescale 1ns/10ps
module tsps_phase_seq_properties
    import tsps_pkg::*;
(
    input wire logic           clock,
    input wire logic           rst,
    input wire logic           scsi_rst_i,
    input wire logic           atn_seen,
    input wire logic           req_oe,
    input wire logic           bsy_oe,
    input wire logic           db_oe,
    input wire tsps_lines_type lines_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_rst_seen;
        $rose(scsi_rst_i);
    endsequence
    sequence s_free;
        !bsy_oe && !req_oe && !db_oe && lines_oe == 3'h0;
    endsequence
    property p_legal;
        req_oe |-> lines_oe != 3'h4 && lines_oe != 3'h5;
    endproperty
    property p_bsy;
        req_oe |-> bsy_oe;
    endproperty
    property p_hold;
        req_oe && !scsi_rst_i |=> $stable(lines_oe);
    endproperty
    property p_between;
        bsy_oe && $past(bsy_oe) && $changed(lines_oe) |-> !req_oe && !$past(req_oe);
    endproperty
    property p_io_data;
        db_oe |-> lines_oe.io && bsy_oe;
    endproperty
    property p_turn;
        $rose(lines_oe.io) |-> !db_oe [*4];
    endproperty
    property p_setup;
        $rose(req_oe) && lines_oe.io |-> $past(db_oe, 2);
    endproperty
    property p_atn;
        $rose(req_oe) && lines_oe == 3'h6 |-> atn_seen;
    endproperty
    property p_clear;
        s_rst_seen |-> ##[1:5] s_free;
    endproperty
    a_legal: assert property (p_legal)
        else $error("bad phase lines");
    a_bsy: assert property (p_bsy)
        else $error("req without bsy");
    a_hold: assert property (p_hold)
        else $error("phase lines moved in handshake");
    a_between: assert property (p_between)
        else $error("req moved between phases");
    a_io_data: assert property (p_io_data)
        else $error("data driven with io low");
    a_turn: assert property (p_turn)
        else $error("data driven too soon");
    a_setup: assert property (p_setup)
        else $error("req before data setup");
    a_atn: assert property (p_atn)
        else $error("msg out byte without atn");
    a_clear: assert property (p_clear)
        else $error("bus not released");
endmodule

bind tsps_phase_seq tsps_phase_seq_properties u_props (
    .clock(clock), .rst(rst), .scsi_rst_i(scsi_rst_i), .atn_seen(atn_seen),
    .req_oe(req_oe), .bsy_oe(bsy_oe), .db_oe(db_oe), .lines_oe(lines_oe)
);

// file: tsps_initiator_model.sv
`timescale 1ns/10ps
module tsps_initiator_model
    import tsps_pkg::*;
(
    input  wire logic           clock,
    input  wire logic           rst,
    input  wire logic           slow,
    input  wire logic           atn_load,
    input  wire logic [3:0]     atn_cnt,
    input  wire logic           req_oe,
    input  wire tsps_lines_type lines_oe,
    output logic                ack_i,
    output logic                atn_i,
    output logic [8:0]          ini_db
);
    logic [3:0] dly;
    logic [3:0] left;
    logic [7:0] b;
    always @(posedge clock) begin
        dly <= dly + 4'h1;
        if (rst) begin
            ack_i <= 1'b0;
            atn_i <= 1'b0;
            dly <= 4'h0;
            ini_db <= 9'h155;
        end else if (atn_load) begin
            atn_i <= 1'b1;
            left <= atn_cnt;
        end else if (req_oe && !ack_i) begin
            if (dly == 4'h0 && !lines_oe.io) begin
                b = 8'($urandom);
                ini_db <= {~^b, b};
            end
            if (lines_oe == 3'h6 && left == 4'h1) atn_i <= 1'b0;
            if (dly == (slow ? 4'h9 : 4'h2)) begin
                ack_i <= 1'b1;
                dly <= 4'h0;
                if (lines_oe == 3'h6) left <= left - 4'h1;
            end
        end else if (!req_oe && ack_i) begin
            if (dly >= (slow ? 4'h5 : 4'h0)) ack_i <= 1'b0;
        end else begin
            dly <= 4'h0;
            // Released lines show a moving pattern
            if (!ack_i && !req_oe) ini_db <= ~ini_db;
        end
    end
endmodule

// file: tsps_phase_seq_tb.sv
`timescale 1ns/10ps
`include "tsps_params.svh"
module tsps_phase_seq_tb
    import tsps_pkg::*;
;
    logic           clock = 1'b0;
    logic           rst = 1'b1;
    logic           cmd_valid = 1'b0;
    tsps_cmd_type   cmd = '0;
    logic           tx_valid = 1'b0;
    logic [7:0]     tx_data = 8'h00;
    logic           xfer_all = 1'b0;
    logic           scsi_rst_i = 1'b0;
    logic           slow = 1'b0;
    logic           atn_load = 1'b0;
    logic [3:0]     atn_cnt = 4'h0;
    logic           ack_q = 1'b0;
    logic           req_q = 1'b0;
    logic           bad_par = 1'b0;
    logic           cmd_ready, done, done_err, tx_ready, atn_seen, sdp_due;
    logic           db_oe, bsy_oe, req_oe, ack_i, atn_i;
    logic [8:0]     db_o, ini_db;
    wire  [8:0]     db_i = db_oe ? db_o : ini_db ^ {bad_par, 8'h00};
    tsps_rx_type    rx;
    tsps_lines_type lines_oe;
    logic [2:0]     cur_ph;
    logic [7:0]     t;
    logic           doneq[$];
    logic [7:0]     rxq[$];
    logic [7:0]     txq[$];
    int             err_total = 0;
    int             n_tests = 0;
    int             cyc = 0;
    localparam logic [2:0] PHS [7] = '{`TSPS_PH_COMMAND, `TSPS_PH_DATA_IN, `TSPS_PH_DATA_IN,
        `TSPS_PH_DATA_OUT, `TSPS_PH_STATUS, 3'h4, `TSPS_PH_MSG_IN};
    localparam int NS [7] = '{2, 3, 2, 2, 1, 1, 2};

    always #2.5 clock = ~clock;

    tsps_phase_seq #(.T_SETTLE_NS(10), .T_DESKEW_NS(5), .T_CSKEW_NS(5), .T_DREL_NS(10)) DUT (
        .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .done(done), .done_err(done_err), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx(rx), .xfer_all(xfer_all), .atn_seen(atn_seen),
        .sdp_due(sdp_due), .scsi_rst_i(scsi_rst_i), .atn_i(atn_i), .ack_i(ack_i),
        .db_i(db_i), .db_o(db_o), .db_oe(db_oe), .bsy_oe(bsy_oe), .req_oe(req_oe),
        .lines_oe(lines_oe)
    );
    tsps_initiator_model u_ini (
        .clock(clock), .rst(rst), .slow(slow), .atn_load(atn_load), .atn_cnt(atn_cnt),
        .req_oe(req_oe), .lines_oe(lines_oe), .ack_i(ack_i), .atn_i(atn_i), .ini_db(ini_db)
    );

    task automatic chk_bus(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t bus got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("tests %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_cmd(input tsps_op_type op, input logic [2:0] ph,
                          input logic [15:0] n, input logic e);
        cmd_valid <= 1'b1;
        cmd <= {op, ph, n};
        do @(posedge clock); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        doneq.push_back(e);
        cur_ph <= ph;
        do @(posedge clock); while (done !== 1'b1);
    endtask
    task automatic push_tx(input int n);
        repeat (n) begin
            tx_valid <= 1'b1;
            tx_data <= 8'($urandom);
            @(posedge clock);
        end
        tx_valid <= 1'b0;
    endtask
    task automatic atn(input logic [3:0] n);
        atn_cnt <= n;
        atn_load <= 1'b1;
        @(posedge clock);
        atn_load <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    // Timeout far above the thousand or so cycles the run needs
    always @(posedge clock) begin
        ack_q <= ack_i;
        req_q <= req_oe;
        cyc <= cyc + 1;
        if (tx_valid && tx_ready) txq.push_back(tx_data);
        if (ack_i && !ack_q && !lines_oe.io) rxq.push_back(db_i[7:0]);
        if (done === 1'b1) chk_flag(done_err, doneq.pop_front());
        if (rx.valid === 1'b1) chk_bus(rx[8:0], {rxq.pop_front(), bad_par});
        if (req_oe === 1'b1 && !req_q && lines_oe.io) begin
            t = txq.pop_front();
            chk_bus(db_o, {~^t, t});
        end
        if (req_oe === 1'b1 && !req_q) chk_bus({6'h00, lines_oe}, {6'h00, cur_ph});
        if (cyc == 40000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        void'($urandom(83));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        do_cmd(TSPS_CMD_PHASE, `TSPS_PH_COMMAND, 16'h0001, 1'b1);
        do_cmd(TSPS_CMD_CONNECT, 3'h0, 16'h0000, 1'b0);
        chk_flag(sdp_due, 1'b0);
        do_cmd(TSPS_CMD_CONNECT, 3'h0, 16'h0000, 1'b1);
        for (int i = 0; i < 7; i++) begin
            slow <= i[0];
            xfer_all <= (i == 3);
            if (PHS[i][0]) push_tx(NS[i]);
            do_cmd(TSPS_CMD_PHASE, PHS[i], 16'(NS[i]), i == 5);
            if (i == 3) chk_flag(sdp_due, 1'b0);
            if (i == 4) chk_flag(sdp_due, 1'b1);
        end
        do_cmd(TSPS_CMD_PHASE, `TSPS_PH_MSG_OUT, 16'h0001, 1'b1);
        atn(4'h3);
        bad_par <= 1'b1;
        do_cmd(TSPS_CMD_PHASE, `TSPS_PH_MSG_OUT, 16'h0001, 1'b1);
        bad_par <= 1'b0;
        atn(4'h3);
        do_cmd(TSPS_CMD_PHASE, `TSPS_PH_MSG_OUT, 16'h0001, 1'b0);
        chk_flag(atn_seen, 1'b0);
        atn(4'h1);
        do_cmd(TSPS_CMD_PHASE, `TSPS_PH_MSG_OUT, 16'h0001, 1'b1);
        push_tx(1);
        do_cmd(TSPS_CMD_PHASE, `TSPS_PH_DATA_IN, 16'h0001, 1'b0);
        do_cmd(TSPS_CMD_PHASE, `TSPS_PH_MSG_OUT, 16'h0001, 1'b0);
        do_cmd(TSPS_CMD_FREE, 3'h0, 16'h0000, 1'b0);
        do_cmd(TSPS_CMD_FREE, 3'h0, 16'h0000, 1'b1);
        do_cmd(TSPS_CMD_CONNECT, 3'h0, 16'h0000, 1'b0);
        slow <= 1'b1;
        fork
            do_cmd(TSPS_CMD_PHASE, `TSPS_PH_DATA_OUT, 16'h0028, 1'b1);
            begin
                repeat (30) @(posedge clock);
                scsi_rst_i <= 1'b1;
                repeat (10) @(posedge clock);
                scsi_rst_i <= 1'b0;
            end
        join
        rxq.delete();
        do_cmd(TSPS_CMD_CONNECT, 3'h0, 16'h0000, 1'b0);
        push_tx(20);
        @(posedge clock);
        chk_bus(9'(txq.size()), 9'h010);
        do_cmd(TSPS_CMD_PHASE, `TSPS_PH_DATA_IN, 16'h0010, 1'b0);
        chk_bus(9'(txq.size()), 9'h000);
        close_out();
    end
endmodule
